// File: spi_port_pkg.sv
package spi_port_pkg;

  // register addresses on the special-function register port
  localparam logic [7:0] DATA_ADDR   = 8'hF7;
  localparam logic [7:0] CTRL_ADDR   = 8'hF8;

  // reset values
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // control field positions
  localparam int DONE_POS   = 7;
  localparam int COLLIDE_POS = 6;
  localparam int OWNER_POS  = 5;
  localparam int MASTER_POS = 4;
  localparam int IDLE_POS   = 3;
  localparam int PHASE_POS  = 2;
  localparam int RATE_HI_POS = 1;
  localparam int RATE_LO_POS = 0;

  // timing counts
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam logic [4:0] LAST_EDGE     = 5'h0F;
  localparam logic [3:0] HALF_DIV_BASE = 4'h1;

  typedef struct packed {
    logic       done;
    logic       collide;
    logic       owner;
    logic       master;
    logic       idleLevel;
    logic       phase;
    logic [1:0] rate;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } sfr_req_t;

  typedef enum logic [2:0] {
    M_IDLE  = 3'b001,
    M_RUN   = 3'b010,
    M_DRAIN = 3'b100
  } master_state_t;

endpackage

// File: bit_sync_2ff.sv
`timescale 1ns/100ps
module bit_sync_2ff #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic meta_reg;

  // only the second stage reads the first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      q        <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// File: sclk_rate_divider.sv
`timescale 1ns/100ps
module sclk_rate_divider
  import spi_port_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [1:0] rate,
  output logic            halfTick
);

  logic [3:0] cnt_reg;
  logic [3:0] limit;

  // half period is 1, 2, 4 or 8 core clocks
  assign limit = 4'(HALF_DIV_BASE << rate) - 4'h1;

  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin
      cnt_reg  <= 4'h0;
      halfTick <= 1'b0;
    end else if (cnt_reg == limit) begin
      cnt_reg  <= 4'h0;
      halfTick <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 4'h1;
      halfTick <= 1'b0;
    end
  end

endmodule

// File: spi_master_slave_port.sv
`timescale 1ns/100ps
module spi_master_slave_port
  import spi_port_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire sfr_req_t   sfrReq,
  output logic [7:0]      sfrRdata,
  input  wire logic       sclkIn,
  output logic            sclkOut,
  output logic            sclkOe,
  input  wire logic       mosiIn,
  output logic            mosiOut,
  output logic            mosiOe,
  input  wire logic       misoIn,
  output logic            misoOut,
  output logic            misoOe,
  input  wire logic       slaveSelN,
  output logic            portSelected
);

  ctrl_t         ctrl_reg;
  logic [7:0]    txByte_reg;
  logic [7:0]    rxData_reg;
  logic [7:0]    sfrRdata_reg;
  master_state_t state_reg;
  logic [4:0]    edgeCnt_reg;
  logic [7:0]    mShift_reg;
  logic [7:0]    mRx_reg;
  logic [1:0]    samplePipe_reg;
  logic          mosiOut_reg;
  logic          sclkOut_reg;
  logic          sclkOe_reg;
  logic          mosiOe_reg;
  logic          misoOe_reg;
  logic          doneSeen_reg;
  logic          slavePending_reg;
  logic          ssPrev_reg;

  logic          misoSync;
  logic          ssSync;
  logic          doneSync;
  logic          midSync;
  logic          halfTick;

  logic          slaveMode;
  logic          masterMode;
  logic          busy;
  logic          dataWrite;
  logic          dataRead;
  logic          ctrlWrite;
  logic          leadingEdge;
  logic          launchEdge;
  logic          masterCommit;
  logic          slaveEvent;
  logic          slaveCommit;
  logic          ssRise;

  // link domain
  logic          sclkEff;
  logic [2:0]    rxCnt_reg;
  logic [7:0]    rxShift_reg;
  logic          midByte_reg;
  logic [7:0]    slvByte_reg;
  logic          doneTgl_reg;
  logic [2:0]    txCnt_reg;
  logic [2:0]    txIdx;

  // pins belong to this port only while owner is set
  assign masterMode = ctrl_reg.owner & ctrl_reg.master;
  assign slaveMode  = ctrl_reg.owner & ~ctrl_reg.master;

  assign dataWrite  = sfrReq.we && (sfrReq.addr == DATA_ADDR);
  assign dataRead   = sfrReq.re && (sfrReq.addr == DATA_ADDR);
  assign ctrlWrite  = sfrReq.we && (sfrReq.addr == CTRL_ADDR);

  assign busy = (state_reg != M_IDLE) | (slaveMode & midSync);

  bit_sync_2ff #(.RESET_VAL(1'b0)) misoSyncU (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     (misoIn),
    .q     (misoSync)
  );

  bit_sync_2ff #(.RESET_VAL(1'b1)) ssSyncU (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     (slaveSelN),
    .q     (ssSync)
  );

  bit_sync_2ff #(.RESET_VAL(1'b0)) doneSyncU (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     (doneTgl_reg),
    .q     (doneSync)
  );

  bit_sync_2ff #(.RESET_VAL(1'b0)) midSyncU (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     (midByte_reg),
    .q     (midSync)
  );

  // rate field sets the half period of the master clock
  sclk_rate_divider rateDivU (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .run      (state_reg == M_RUN),
    .rate     (ctrl_reg.rate),
    .halfTick (halfTick)
  );

  // even edge index is the leading edge of a clock period
  assign leadingEdge = ~edgeCnt_reg[0];
  // phase picks which edge launches data
  assign launchEdge  = leadingEdge ? ctrl_reg.phase : ~ctrl_reg.phase;

  // data write starts a burst of eight clock periods
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg   <= M_IDLE;
      edgeCnt_reg <= 5'h00;
    end else begin
      case (state_reg)
        M_IDLE: begin
          edgeCnt_reg <= 5'h00;
          if (dataWrite && masterMode) begin
            state_reg <= M_RUN;
          end
        end
        M_RUN: begin
          if (!ctrl_reg.owner) begin
            state_reg <= M_IDLE;
          end else if (halfTick) begin
            edgeCnt_reg <= edgeCnt_reg + 5'h01;
            if (edgeCnt_reg == LAST_EDGE) begin
              state_reg <= M_DRAIN;
            end
          end
        end
        M_DRAIN: begin
          if (samplePipe_reg == 2'b00) begin
            state_reg <= M_IDLE;
          end
        end
        default: begin
          state_reg <= M_IDLE;
        end
      endcase
    end
  end

  // received byte lands once the last sample has settled
  assign masterCommit = (state_reg == M_DRAIN) && (samplePipe_reg == 2'b00);

  // generated clock idles at the chosen level and toggles per tick
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclkOut_reg <= 1'b0;
    end else if (state_reg == M_RUN && halfTick) begin
      sclkOut_reg <= ~sclkOut_reg;
    end else if (state_reg == M_IDLE) begin
      sclkOut_reg <= ctrl_reg.idleLevel;
    end
  end

  // transmit shifter sends the top bit first
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mShift_reg  <= DATA_RESET;
      mosiOut_reg <= 1'b0;
    end else if (state_reg == M_IDLE && dataWrite && masterMode) begin
      if (ctrl_reg.phase) begin
        mShift_reg <= sfrReq.wdata;
      end else begin
        // trailing-edge launch: first bit must stand before the first edge
        mosiOut_reg <= sfrReq.wdata[7];
        mShift_reg  <= {sfrReq.wdata[6:0], 1'b0};
      end
    end else if (state_reg == M_RUN && halfTick && launchEdge) begin
      // MOSI driven from the master shifter
      mosiOut_reg <= mShift_reg[7];
      mShift_reg  <= {mShift_reg[6:0], 1'b0};
    end
  end

  // MISO read as input, two stages late, so sampling lags to match
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      samplePipe_reg <= 2'b00;
      mRx_reg        <= DATA_RESET;
    end else begin
      samplePipe_reg <= {samplePipe_reg[0],
                         (state_reg == M_RUN) & halfTick & ~launchEdge};
      // one bit taken per clock period
      if (samplePipe_reg[1]) begin
        mRx_reg <= {mRx_reg[6:0], misoSync};
      end
    end
  end

  // slave byte completion handed over by toggle
  assign slaveEvent = doneSync != doneSeen_reg;
  assign ssRise     = ssSync & ~ssPrev_reg;

  // phase one lands at the eighth clock, phase zero at select rise
  assign slaveCommit = slaveMode &&
                       ((slaveEvent && ctrl_reg.phase) ||
                        (slavePending_reg && ssRise && !ctrl_reg.phase));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      doneSeen_reg     <= 1'b0;
      ssPrev_reg       <= 1'b1;
      slavePending_reg <= 1'b0;
    end else begin
      doneSeen_reg <= doneSync;
      ssPrev_reg   <= ssSync;
      if (!slaveMode || slaveCommit) begin
        slavePending_reg <= 1'b0;
      end else if (slaveEvent && !ctrl_reg.phase) begin
        slavePending_reg <= 1'b1;
      end
    end
  end

  // data register: write side feeds the shifters, read side holds received
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txByte_reg <= DATA_RESET;
    end else if (dataWrite && !busy) begin
      // slave transmit byte loaded by software write
      txByte_reg <= sfrReq.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rxData_reg <= DATA_RESET;
    end else if (masterCommit) begin
      rxData_reg <= mRx_reg;
    end else if (slaveCommit) begin
      rxData_reg <= slvByte_reg;
    end
  end

  // control register; hardware sets win over software clears
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= ctrl_t'(CTRL_RESET);
    end else begin
      if (ctrlWrite) begin
        ctrl_reg.owner     <= sfrReq.wdata[OWNER_POS];
        ctrl_reg.master    <= sfrReq.wdata[MASTER_POS];
        ctrl_reg.idleLevel <= sfrReq.wdata[IDLE_POS];
        ctrl_reg.phase     <= sfrReq.wdata[PHASE_POS];
        ctrl_reg.rate      <= {sfrReq.wdata[RATE_HI_POS],
                               sfrReq.wdata[RATE_LO_POS]};
      end
      // done set per byte, cleared by write of 0 or data read
      if (masterCommit || slaveCommit) begin
        ctrl_reg.done <= 1'b1;
      end else if (dataRead ||
                   (ctrlWrite && !sfrReq.wdata[DONE_POS])) begin
        ctrl_reg.done <= 1'b0;
      end
      // collision set by data write mid-transfer
      if (dataWrite && busy) begin
        ctrl_reg.collide <= 1'b1;
      end else if (ctrlWrite && !sfrReq.wdata[COLLIDE_POS]) begin
        ctrl_reg.collide <= 1'b0;
      end
    end
  end

  // register read, answered one cycle after the request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sfrRdata_reg <= 8'h00;
    end else if (sfrReq.re && sfrReq.addr == DATA_ADDR) begin
      sfrRdata_reg <= rxData_reg;
    end else if (sfrReq.re && sfrReq.addr == CTRL_ADDR) begin
      // bit 0 shows the select pin while slave
      sfrRdata_reg <= {ctrl_reg.done, ctrl_reg.collide, ctrl_reg.owner,
                       ctrl_reg.master, ctrl_reg.idleLevel,
                       ctrl_reg.phase, ctrl_reg.rate[1],
                       slaveMode ? ssSync : ctrl_reg.rate[0]};
    end else begin
      sfrRdata_reg <= 8'h00;
    end
  end

  // clock and data enables follow mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclkOe_reg <= 1'b0;
      mosiOe_reg <= 1'b0;
      misoOe_reg <= 1'b0;
    end else begin
      sclkOe_reg <= masterMode;
      mosiOe_reg <= masterMode;
      // the master path never looks at its own select pin
      // slave drives MISO only while selected
      misoOe_reg <= slaveMode & ~ssSync;
    end
  end

  // sample on rising edge of this clock, launch on falling edge
  assign sclkEff = sclkIn ^ (ctrl_reg.idleLevel ^ ctrl_reg.phase);

  // select high holds the slave counters at rest
  always_ff @(posedge sclkEff or posedge slaveSelN) begin
    if (slaveSelN) begin
      rxCnt_reg   <= 3'h0;
      rxShift_reg <= 8'h00;
      midByte_reg <= 1'b0;
    end else begin
      rxShift_reg <= {rxShift_reg[6:0], mosiIn};
      rxCnt_reg   <= rxCnt_reg + 3'h1;
      midByte_reg <= rxCnt_reg != LAST_BIT;
    end
  end

  always_ff @(posedge sclkEff or negedge rst_n) begin
    if (!rst_n) begin
      slvByte_reg <= 8'h00;
      doneTgl_reg <= 1'b0;
    end else if (!slaveSelN && rxCnt_reg == LAST_BIT) begin
      slvByte_reg <= {rxShift_reg[6:0], mosiIn};
      doneTgl_reg <= ~doneTgl_reg;
    end
  end

  always_ff @(negedge sclkEff or posedge slaveSelN) begin
    if (slaveSelN) begin
      txCnt_reg <= 3'h0;
    end else begin
      txCnt_reg <= txCnt_reg + 3'h1;
    end
  end

  // tx byte is held from the first received bit to the eighth, seen two core clocks late: writes then are refused
  assign txIdx = txCnt_reg - {2'b00, ctrl_reg.phase};

  // MISO driven from the loaded byte, top bit first
  assign misoOut      = txByte_reg[LAST_BIT - txIdx];
  assign sfrRdata     = sfrRdata_reg;
  assign sclkOut      = sclkOut_reg;
  assign sclkOe       = sclkOe_reg;
  assign mosiOut      = mosiOut_reg;
  assign mosiOe       = mosiOe_reg;
  assign misoOe       = misoOe_reg;
  assign portSelected = ctrl_reg.owner;

endmodule

// File: spi_port_checker.sv
`timescale 1ns/100ps
module spi_port_checker
  import spi_port_pkg::*;
(
  input wire logic     mclk,
  input wire logic     rst_n,
  input wire sfr_req_t sfrReq,
  input wire logic     sclkOut,
  input wire logic     sclkOe,
  input wire logic     mosiOut,
  input wire logic     mosiOe,
  input wire logic     misoOe,
  input wire logic     slaveSelN,
  input wire logic     portSelected
);
  logic       inBurst;
  logic       sclkPrev;
  logic       startLvl;
  logic [4:0] edges;
  logic [3:0] gap;
  logic [3:0] lastGap;
  wire logic  tog = sclkOut != sclkPrev;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge mclk) sclkPrev <= sclkOut;

  // edges and their spacing since a master data write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      inBurst  <= 1'b0;
      edges    <= 5'h00;
      gap      <= 4'h0;
      lastGap  <= 4'h0;
      startLvl <= 1'b0;
    end else if (!inBurst) begin
      edges <= 5'h00;
      gap   <= 4'h0;
      if (sfrReq.we && sfrReq.addr == DATA_ADDR && sclkOe) begin
        inBurst  <= 1'b1;
        startLvl <= sclkOut;
      end
    end else begin
      gap <= tog ? 4'h1 : gap + 4'h1;
      if (tog) begin
        edges   <= edges + 5'h01;
        lastGap <= gap;
      end
      if (!sclkOe || (tog && edges == 5'h0F))
        inBurst <= 1'b0;
    end
  end

  a_clk_owner: assert property (sclkOe |-> portSelected)
    else $error("clock driven while pins are handed away");
  a_mosi_oe: assert property (mosiOe == sclkOe)
    else $error("data out enable differs from clock enable");
  a_miso_slave: assert property (misoOe |-> !sclkOe)
    else $error("slave data driven in master mode");
  a_miso_select: assert property ($rose(misoOe) |->
    $past(slaveSelN, 3) == 1'b0)
    else $error("slave output enabled without select");
  a_first_edge: assert property ($rose(inBurst) |-> ##[1:10] tog)
    else $error("no clock edge after data write");
  a_halves_equal: assert property (
    tog && inBurst && edges >= 5'h02 |-> gap == lastGap)
    else $error("uneven clock half periods");
  a_rate_set: assert property (
    tog && inBurst && edges != 5'h00 |-> gap inside {1, 2, 4, 8})
    else $error("half period not a divider setting");
  a_burst_ends: assert property ($rose(inBurst) |->
    ##[16:160] !inBurst)
    else $error("burst did not finish sixteen edges");
  a_mosi_on_edge: assert property (
    inBurst && edges != 5'h00 && $changed(mosiOut) |-> tog)
    else $error("data changed away from a clock edge");
  a_idle_return: assert property (
    $fell(inBurst) |-> sclkOut == startLvl)
    else $error("clock not back at idle level");
endmodule

bind spi_master_slave_port spi_port_checker chk (.mclk(mclk),
  .rst_n(rst_n), .sfrReq(sfrReq), .sclkOut(sclkOut), .sclkOe(sclkOe),
  .mosiOut(mosiOut), .mosiOe(mosiOe), .misoOe(misoOe),
  .slaveSelN(slaveSelN), .portSelected(portSelected));

// File: spi_far_end.sv
`timescale 1ns/100ps
module spi_far_end (
  input  wire logic       beMaster,
  input  wire logic       clock_idle_level,
  input  wire logic       clock_phase_select,
  input  wire logic       go,
  input  wire logic [7:0] txByte,
  input  wire logic       sclkPin,
  input  wire logic       mosiPin,
  input  wire logic       misoPin,
  output logic            sclkDrv,
  output logic            dataDrv,
  output logic            selN,
  output logic [7:0]      rxByte,
  output int              bitsIn
);
  int         launched;
  logic       armed;
  logic [7:0] sh;

  initial {armed, selN, sclkDrv, dataDrv} = 4'h4;

  task automatic put;
    int idx;
    idx = clock_phase_select ? 8 - launched : 7 - launched;
    // a released line shows the inverse of its last value
    dataDrv = (idx >= 0 && idx < 8) ? sh[idx] : ~dataDrv;
  endtask

  // launch on one edge, sample on the other
  always @(sclkPin) begin
    if (armed) begin
      if ((sclkPin !== clock_idle_level) == clock_phase_select) begin
        launched++;
        put();
      end else begin
        rxByte = {rxByte[6:0], beMaster ? misoPin : mosiPin};
        bitsIn++;
      end
      if (launched == 8 && bitsIn == 8)
        armed = 1'b0;
    end
  end

  always @(posedge go) begin
    sh = txByte;
    launched = 0;
    bitsIn = 0;
    rxByte = 8'h00;
    put();
    if (beMaster)
      sclkDrv = clock_idle_level;
    #1 armed = 1'b1;
    if (beMaster) begin
      selN = 1'b0;
      #103;
      repeat (16) #16 sclkDrv = ~sclkDrv;
      #103 selN = 1'b1;
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/100ps
module tb;
  import spi_port_pkg::*;
  logic       mclk, rst_n, go, clock_idle_level, clock_phase_select, fMaster;
  logic       rdSeen = 1'b0;
  logic       sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe;
  logic       portSelected, sclkDrv, dataDrv, selN;
  logic [7:0] sfrRdata, fTx, fRx, expQ[$];
  int         fBits, seed;
  int         mismatches = 0;
  int         checked = 0;
  sfr_req_t   req;
  wire logic  sclkW = sclkOe ? sclkOut : sclkDrv;
  wire logic  mosiW = mosiOe ? mosiOut : dataDrv;
  wire logic  misoW = misoOe ? misoOut : dataDrv;

  spi_master_slave_port uut (.mclk(mclk), .rst_n(rst_n), .sfrReq(req),
    .sfrRdata(sfrRdata), .sclkIn(sclkW), .sclkOut(sclkOut),
    .sclkOe(sclkOe), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe),
    .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe),
    .slaveSelN(selN), .portSelected(portSelected));
  spi_far_end far (.beMaster(fMaster), .clock_idle_level(clock_idle_level), .clock_phase_select(clock_phase_select), .go(go),
    .txByte(fTx), .sclkPin(sclkW), .mosiPin(mosiW), .misoPin(misoW),
    .sclkDrv(sclkDrv), .dataDrv(dataDrv), .selN(selN), .rxByte(fRx),
    .bitsIn(fBits));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // one request cycle, then one quiet cycle
  task automatic acc(input logic [7:0] a, input logic [7:0] d,
                     input logic w);
    req = '{a, d, w, ~w};
    tick(1);
    req = '0;
    tick(1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    acc(a, 8'h00, 1'b0);
  endtask

  // read answers are compared in the cycle after the request is taken
  always @(negedge mclk) begin
    if (rdSeen)
      cmp8(sfrRdata, expQ.pop_front());
    rdSeen = req.re;
  end

  task automatic kick;
    go = 1'b1;
    tick(1);
    go = 1'b0;
  endtask

  task automatic frame_wait;
    for (int n = 0; n < 400 && !(fBits == 8 && selN); n++)
      tick(1);
    tick(12);
  endtask

  task automatic mxfer(input logic [2:0] i);
    logic [7:0] tx, rx, c;
    tx = 8'($random(seed));
    rx = 8'($random(seed));
    c = {4'h3, i[2], i[0] ^ i[2], i[1:0]};
    {clock_idle_level, clock_phase_select} = c[3:2];
    fMaster = 1'b0;
    fTx = rx;
    wr(CTRL_ADDR, c);
    tick(3);
    cmp8({5'h00, portSelected, sclkOe, mosiOe}, 8'h07);
    kick();
    wr(DATA_ADDR, tx);
    wr(DATA_ADDR, ~tx);
    frame_wait();
    cmp8(fRx, tx);
    rd(CTRL_ADDR, c | 8'hC0);
    rd(DATA_ADDR, rx);
    rd(CTRL_ADDR, c | 8'h40);
    wr(CTRL_ADDR, c);
    rd(CTRL_ADDR, c);
  endtask

  task automatic sxfer(input logic [1:0] m);
    logic [7:0] tx, rx, c;
    tx = 8'($random(seed));
    rx = 8'($random(seed));
    c = {4'h2, m, 2'h0};
    {clock_idle_level, clock_phase_select} = m;
    fMaster = 1'b1;
    fTx = rx;
    wr(CTRL_ADDR, c);
    wr(DATA_ADDR, tx);
    rd(CTRL_ADDR, c | 8'h01);
    kick();
    tick(3);
    cmp8({5'h00, portSelected, sclkOe, misoOe}, 8'h05);
    rd(CTRL_ADDR, c);
    frame_wait();
    cmp8({7'h00, misoOe}, 8'h00);
    cmp8(fRx, tx);
    rd(CTRL_ADDR, c | 8'h81);
    rd(DATA_ADDR, rx);
  endtask

  initial begin
    seed = 32'hD0459B83;
    {go, clock_idle_level, clock_phase_select, fMaster, rst_n} = 5'h00;
    req = '0;
    fTx = 8'h00;
    tick(5);
    rst_n = 1'b1;
    rd(CTRL_ADDR, CTRL_RESET);
    rd(DATA_ADDR, DATA_RESET);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 8; i++)
      mxfer(3'(i));
    for (int m = 0; m < 4; m++)
      sxfer(2'(m));
    wr(CTRL_ADDR, 8'h10);
    tick(3);
    cmp8({5'h00, portSelected, sclkOe, mosiOe}, 8'h00);
    tick(4);
    wrap_up();
  end

  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule
